// ===== hdl/epiw_pkg.sv
// Constants, register map and carrier types of the external pin interrupt and wake block.
package epiw_pkg;

  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned STARTUP_TIME_NS = 600;
  localparam int unsigned STARTUP_CYC = (STARTUP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STARTUP_LAST = 4'(STARTUP_CYC - 1);
  localparam logic [3:0] STARTUP_ZERO = 4'h0;
  localparam logic [3:0] STARTUP_ONE = 4'h1;

  localparam int unsigned NUM_PC = 6;

  localparam logic [7:0] OFS_SENSE_CTRL = 8'h00;
  localparam logic [7:0] OFS_EXT_INT_MASK = 8'h04;
  localparam logic [7:0] OFS_PC_MASK = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam logic [7:0] RST_SENSE_CTRL = 8'h00;
  localparam logic [5:0] RST_PC_MASK = 6'h00;

  localparam int SENSE_LSB = 0;
  localparam int SMODE_LSB = 3;
  localparam int SLEEP_EN_BIT = 5;
  localparam int MASK_DED_BIT = 6;
  localparam int MASK_PC_BIT = 5;
  localparam int FLAG_DED_BIT = 0;
  localparam int FLAG_PC_BIT = 1;
  localparam int STAT_PC_LSB = 1;
  localparam int STAT_SLEEP_BIT = 7;
  localparam int STAT_CLAMP_BIT = 8;

  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_NOISE = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_ENTER,
    ST_SLEEP,
    ST_STARTUP,
    ST_RESUME
  } epiw_state_t;

  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic per;
    logic osc;
  } epiw_clk_en_t;

  typedef struct packed {
    logic mem_ready;
    logic serial_start;
    logic converter;
    logic watchdog;
    logic other_io;
  } epiw_wake_src_t;

endpackage

// ===== hdl/epiw_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module epiw_sync #(
  parameter int W = 1
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = D;
    nxt_q = meta_ff;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      meta_ff <= '0;
      Q <= '0;
    end else begin
      meta_ff <= nxt_meta;
      Q <= nxt_q;
    end
  end

endmodule

// ===== hdl/epiw_top.sv
// External pin interrupt, pin-change detection, sleep sequencing and input clamp control.
`timescale 1ns/1ps
// Functional notes
// - Two sense bits pick low level, any change, falling or rising edge.
// - A toggle on any unmasked pin-change input raises the pin-change request.
// - Detection watches the pad level, so pins driven as outputs still trigger.
// - Pin-change detection needs no I/O clock and wakes from every sleep mode.
// - Enabled low-level mode keeps the request asserted while the pin stays low.
// - Edges are detected only while the I/O clock runs; low level always.
// - A low level that vanishes during start-up wakes but gives no interrupt.
// - Dedicated interrupt needs both global enable and its own mask bit.
// - The pin is synchronised before edge detection; one-cycle pulses suffice.
// - Deep sleep modes clamp digital inputs to ground.
// - The clamp is lifted on pins whose interrupt is enabled.
// - A high disabled edge pin sets its flag on resume from clamping sleep.
// - Each sleep mode accepts only its own set of wake-up sources.
// - Each sleep mode keeps only its own set of clocks running.
// - Mask register bit 6 enables the dedicated pin, bit 5 pin change.
// - Sleep mode select: 00 idle, 01 noise reduction, 10 power-down.
module epiw_top
  import epiw_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic DEDICATED_INT_PIN,
  input wire logic [5:0] PIN_CHANGE_INPUTS,
  input wire logic GLOBAL_INT_ENABLE,
  input wire logic SLEEP_CMD,
  input wire logic ACK_DEDICATED,
  input wire logic ACK_PIN_CHANGE,
  input wire epiw_wake_src_t WAKE_SRC,
  output logic IRQ_DEDICATED,
  output logic IRQ_PIN_CHANGE,
  output epiw_clk_en_t CLK_EN,
  output logic SLEEPING,
  output logic DED_CLAMP,
  output logic [5:0] PC_CLAMP
);

  logic [6:0] pins_sync;
  logic ded_eff;
  logic [5:0] pc_eff;

  epiw_sync #(
    .W(7)
  ) u_sync (
    .CLK_SYS(CLK_SYS),
    .RESET_N(RESET_N),
    .D({PIN_CHANGE_INPUTS, DEDICATED_INT_PIN}),
    .Q(pins_sync)
  );

  // Pad levels are read whatever the pin direction; the clamp forces them low.
  assign ded_eff = pins_sync[0] & ~DED_CLAMP;
  assign pc_eff = pins_sync[6:1] & ~PC_CLAMP;

  logic [7:0] ctrl_ff;
  logic mask_ded_ff;
  logic mask_pc_ff;
  logic [5:0] pc_mask_ff;
  logic [7:0] nxt_ctrl;
  logic nxt_mask_ded;
  logic nxt_mask_pc;
  logic [5:0] nxt_pc_mask;
  logic [31:0] nxt_dat;
  logic nxt_ack;
  logic bus_hit;
  logic bus_wr;
  logic sw_clr_ded;
  logic sw_clr_pc;

  logic [1:0] sense;
  logic [1:0] smode;
  logic deep;

  assign sense = ctrl_ff[SENSE_LSB +: 2];
  assign smode = ctrl_ff[SMODE_LSB +: 2];
  assign deep = smode[1];

  epiw_state_t st_ff;
  epiw_state_t st_nxt;
  logic [3:0] su_cnt_ff;
  logic [3:0] nxt_su_cnt;
  logic ded_prev_ff;
  logic nxt_ded_prev;
  logic [5:0] pc_prev_ff;
  logic [5:0] nxt_pc_prev;
  logic ded_flag_ff;
  logic nxt_ded_flag;
  logic pc_flag_ff;
  logic nxt_pc_flag;
  logic ded_edge;
  logic pc_change;
  logic level_low;
  logic wake;
  epiw_clk_en_t nxt_clk_en;
  logic nxt_sleeping;
  logic nxt_ded_clamp;
  logic [5:0] nxt_pc_clamp;
  logic nxt_irq_ded;
  logic nxt_irq_pc;
  logic clamp_state;

  // Register file over a classic Wishbone slave answering one cycle after the request.
  always_comb begin
    bus_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    bus_wr = bus_hit & WB_WE_I & WB_SEL_I[0];
    nxt_ack = bus_hit;
    nxt_ctrl = ctrl_ff;
    nxt_mask_ded = mask_ded_ff;
    nxt_mask_pc = mask_pc_ff;
    nxt_pc_mask = pc_mask_ff;
    sw_clr_ded = 1'b0;
    sw_clr_pc = 1'b0;
    nxt_dat = '0;
    if (WB_ADR_I == OFS_SENSE_CTRL) begin
      nxt_dat[7:0] = ctrl_ff;
      if (bus_wr) begin
        nxt_ctrl = WB_DAT_I[7:0];
      end
    end else if (WB_ADR_I == OFS_EXT_INT_MASK) begin
      nxt_dat[MASK_DED_BIT] = mask_ded_ff;
      nxt_dat[MASK_PC_BIT] = mask_pc_ff;
      if (bus_wr) begin
        nxt_mask_ded = WB_DAT_I[MASK_DED_BIT];
        nxt_mask_pc = WB_DAT_I[MASK_PC_BIT];
      end
    end else if (WB_ADR_I == OFS_PC_MASK) begin
      nxt_dat[5:0] = pc_mask_ff;
      if (bus_wr) begin
        nxt_pc_mask = WB_DAT_I[5:0];
      end
    end else if (WB_ADR_I == OFS_FLAGS) begin
      nxt_dat[FLAG_DED_BIT] = ded_flag_ff;
      nxt_dat[FLAG_PC_BIT] = pc_flag_ff;
      sw_clr_ded = bus_wr & WB_DAT_I[FLAG_DED_BIT];
      sw_clr_pc = bus_wr & WB_DAT_I[FLAG_PC_BIT];
    end else if (WB_ADR_I == OFS_STATUS) begin
      nxt_dat[0] = ded_eff;
      nxt_dat[STAT_PC_LSB +: 6] = pc_eff;
      nxt_dat[STAT_SLEEP_BIT] = SLEEPING;
      nxt_dat[STAT_CLAMP_BIT] = clamp_state;
    end
    if (!bus_hit || WB_WE_I) begin
      nxt_dat = '0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_ff <= RST_SENSE_CTRL;
      mask_ded_ff <= 1'b0;
      mask_pc_ff <= 1'b0;
      pc_mask_ff <= RST_PC_MASK;
      WB_DAT_O <= '0;
      WB_ACK_O <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mask_ded_ff <= nxt_mask_ded;
      mask_pc_ff <= nxt_mask_pc;
      pc_mask_ff <= nxt_pc_mask;
      WB_DAT_O <= nxt_dat;
      WB_ACK_O <= nxt_ack;
    end
  end

  // Event detection, pending flags, sleep sequencing, clocks, clamps and requests.
  always_comb begin
    nxt_ded_prev = CLK_EN.io ? ded_eff : ded_prev_ff;
    ded_edge = 1'b0;
    if (CLK_EN.io) begin
      case (sense)
        SENSE_ANY: ded_edge = ded_eff ^ ded_prev_ff;
        SENSE_FALL: ded_edge = ded_prev_ff & ~ded_eff;
        SENSE_RISE: ded_edge = ~ded_prev_ff & ded_eff;
        default: ded_edge = 1'b0;
      endcase
    end
    nxt_pc_prev = pc_eff;
    pc_change = |((pc_eff ^ pc_prev_ff) & pc_mask_ff);
    // A new event wins over a clear in the same cycle.
    nxt_ded_flag = (ded_flag_ff & ~(ACK_DEDICATED | sw_clr_ded)) | ded_edge;
    nxt_pc_flag = (pc_flag_ff & ~(ACK_PIN_CHANGE | sw_clr_pc)) | pc_change;
    level_low = mask_ded_ff & (sense == SENSE_LOW) & ~ded_eff;
    wake = level_low | (mask_pc_ff & pc_flag_ff);
    case (smode)
      MODE_IDLE: wake = wake | (mask_ded_ff & ded_flag_ff) | (|WAKE_SRC);
      MODE_NOISE: wake = wake | WAKE_SRC.mem_ready | WAKE_SRC.serial_start
        | WAKE_SRC.converter | WAKE_SRC.watchdog;
      default: wake = wake | WAKE_SRC.serial_start | WAKE_SRC.watchdog;
    endcase
    st_nxt = st_ff;
    nxt_su_cnt = su_cnt_ff;
    case (st_ff)
      ST_ACTIVE: begin
        if (SLEEP_CMD && ctrl_ff[SLEEP_EN_BIT]) begin
          st_nxt = ST_ENTER;
        end
      end
      ST_ENTER: begin
        st_nxt = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake) begin
          st_nxt = deep ? ST_STARTUP : ST_RESUME;
          nxt_su_cnt = STARTUP_ZERO;
        end
      end
      ST_STARTUP: begin
        if (su_cnt_ff == STARTUP_LAST) begin
          st_nxt = ST_RESUME;
        end else begin
          nxt_su_cnt = su_cnt_ff + STARTUP_ONE;
        end
      end
      default: begin
        st_nxt = ST_ACTIVE;
      end
    endcase
    nxt_clk_en = '0;
    case (st_nxt)
      ST_ACTIVE: nxt_clk_en = '1;
      ST_ENTER, ST_RESUME: begin
        nxt_clk_en = '1;
        nxt_clk_en.cpu = 1'b0;
      end
      ST_SLEEP: begin
        nxt_clk_en.io = (smode == MODE_IDLE);
        nxt_clk_en.per = (smode == MODE_IDLE);
        nxt_clk_en.adc = ~deep;
        nxt_clk_en.osc = ~deep;
      end
      default: nxt_clk_en.osc = 1'b1;
    endcase
    nxt_sleeping = (st_nxt != ST_ACTIVE);
    // The clamp spans the cycle before and after deep sleep so its edges are seen.
    clamp_state = deep & (st_nxt != ST_ACTIVE);
    nxt_ded_clamp = clamp_state & ~mask_ded_ff;
    nxt_pc_clamp = {NUM_PC{clamp_state}} & ~({NUM_PC{mask_pc_ff}} & pc_mask_ff);
    nxt_irq_ded = GLOBAL_INT_ENABLE & mask_ded_ff & (st_ff == ST_ACTIVE)
      & ((sense == SENSE_LOW) ? ~ded_eff : ded_flag_ff);
    nxt_irq_pc = GLOBAL_INT_ENABLE & mask_pc_ff & (st_ff == ST_ACTIVE) & pc_flag_ff;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= ST_ACTIVE;
      su_cnt_ff <= STARTUP_ZERO;
      ded_prev_ff <= 1'b0;
      pc_prev_ff <= '0;
      ded_flag_ff <= 1'b0;
      pc_flag_ff <= 1'b0;
      CLK_EN <= '1;
      SLEEPING <= 1'b0;
      DED_CLAMP <= 1'b0;
      PC_CLAMP <= '0;
      IRQ_DEDICATED <= 1'b0;
      IRQ_PIN_CHANGE <= 1'b0;
    end else begin
      st_ff <= st_nxt;
      su_cnt_ff <= nxt_su_cnt;
      ded_prev_ff <= nxt_ded_prev;
      pc_prev_ff <= nxt_pc_prev;
      ded_flag_ff <= nxt_ded_flag;
      pc_flag_ff <= nxt_pc_flag;
      CLK_EN <= nxt_clk_en;
      SLEEPING <= nxt_sleeping;
      DED_CLAMP <= nxt_ded_clamp;
      PC_CLAMP <= nxt_pc_clamp;
      IRQ_DEDICATED <= nxt_irq_ded;
      IRQ_PIN_CHANGE <= nxt_irq_pc;
    end
  end

  a_low_level_req: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (GLOBAL_INT_ENABLE && mask_ded_ff && sense == SENSE_LOW && !ded_eff
     && st_ff == ST_ACTIVE) |=> IRQ_DEDICATED)
    else $error("Low level did not hold the dedicated request.");

  a_global_gate: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (!GLOBAL_INT_ENABLE || !mask_ded_ff) |=> !IRQ_DEDICATED)
    else $error("Dedicated request raised without both enables.");

  a_pc_change_set: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (|((pc_eff ^ pc_prev_ff) & pc_mask_ff)) |=> pc_flag_ff)
    else $error("Unmasked pin toggle did not set the pin-change flag.");

  a_pc_masked_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(pc_flag_ff) |-> $past(|((pc_eff ^ pc_prev_ff) & pc_mask_ff)))
    else $error("Pin-change flag set without an unmasked toggle.");

  a_edge_needs_io: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (!CLK_EN.io && !ded_flag_ff) |=> !ded_flag_ff)
    else $error("Edge flag set while the I/O clock was stopped.");

  a_clamp_deep: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_nxt == ST_SLEEP && deep && !mask_ded_ff) |=> DED_CLAMP)
    else $error("Dedicated input not clamped in deep sleep.");

  a_clamp_override: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    mask_ded_ff |=> !DED_CLAMP)
    else $error("Clamp applied to an enabled interrupt pin.");

  a_pdown_clocks: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_nxt == ST_SLEEP && smode == MODE_PDOWN) |=> (CLK_EN == '0) ##1 !CLK_EN.cpu)
    else $error("A clock ran during power-down.");

  a_startup_no_irq: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_ff == ST_STARTUP && sense == SENSE_LOW) |=> !IRQ_DEDICATED)
    else $error("Level request raised during start-up.");

  a_sense_rise: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (CLK_EN.io && sense == SENSE_RISE && !ded_prev_ff && ded_eff) |=> ded_flag_ff)
    else $error("Rising edge missed in rising-edge mode.");

  a_wb_ack_once: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("Bus acknowledge not a single cycle after the request.");

  a_startup_span: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_ff == ST_SLEEP && st_nxt == ST_STARTUP) |=> (st_ff == ST_STARTUP) [*6]
    ##1 (st_ff == ST_RESUME))
    else $error("Start-up wait did not last its full count.");

  a_ack_clears: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (ACK_DEDICATED && !ded_edge) |=> !ded_flag_ff)
    else $error("Acknowledge did not clear the dedicated flag.");

  a_irq_sleep_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_ff != ST_ACTIVE) |=> (!IRQ_DEDICATED && !IRQ_PIN_CHANGE))
    else $error("Request raised while the core was not running.");

  a_pc_clamp_lift: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    mask_pc_ff |=> ((PC_CLAMP & $past(pc_mask_ff)) == 6'h00))
    else $error("Clamp applied to an enabled pin-change input.");

  a_noise_clocks: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_nxt == ST_SLEEP && smode == MODE_NOISE)
    |=> (CLK_EN.adc && CLK_EN.osc && !CLK_EN.io && !CLK_EN.per && !CLK_EN.cpu))
    else $error("Wrong clocks running in noise-reduction sleep.");

endmodule

// ===== tb/epiw_core_model.sv
// Processor core stand-in that acknowledges interrupt requests.
`timescale 1ns/1ps
module epiw_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic auto_ack,
  input wire logic irq_ded,
  input wire logic irq_pc,
  output logic ack_ded,
  output logic ack_pc
);
  logic nxt_ded;
  logic nxt_pc;
  // While auto_ack is set, a request that is seen is taken with a one-cycle acknowledge pulse.
  always_comb begin
    nxt_ded = auto_ack && irq_ded && !ack_ded;
    nxt_pc = auto_ack && irq_pc && !ack_pc;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ded <= 1'b0;
      ack_pc <= 1'b0;
    end else begin
      ack_ded <= nxt_ded;
      ack_pc <= nxt_pc;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the external pin interrupt and wake block.
`timescale 1ns/1ps
module tb_top
  import epiw_pkg::*;
;
  logic CLK_SYS, RESET_N, cyc, stb, we, gie, sleep_cmd, ded_pin, auto_ack;
  logic ack_o, irq_d, irq_p, sleeping, ded_clamp, ack_d, ack_p, expv;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd, rnd;
  logic [5:0] pc_pins, pc_clamp;
  epiw_wake_src_t wake;
  epiw_clk_en_t clk_en;
  logic [4:0] clkexp [4] = '{5'h0f, 5'h05, 5'h00, 5'h00};
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  epiw_top dut_u (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack_o), .DEDICATED_INT_PIN(ded_pin), .PIN_CHANGE_INPUTS(pc_pins),
    .GLOBAL_INT_ENABLE(gie), .SLEEP_CMD(sleep_cmd), .ACK_DEDICATED(ack_d),
    .ACK_PIN_CHANGE(ack_p), .WAKE_SRC(wake), .IRQ_DEDICATED(irq_d),
    .IRQ_PIN_CHANGE(irq_p), .CLK_EN(clk_en), .SLEEPING(sleeping),
    .DED_CLAMP(ded_clamp), .PC_CLAMP(pc_clamp));

  epiw_core_model core_u (.clk(CLK_SYS), .rst_n(RESET_N), .auto_ack(auto_ack),
    .irq_ded(irq_d), .irq_pc(irq_p), .ack_ded(ack_d), .ack_pc(ack_p));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // One classic cycle, held until acknowledge is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    do begin
      @(posedge CLK_SYS);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
  endtask

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    int n;
    RESET_N = 1'b0;
    {cyc, stb, we, gie, sleep_cmd, auto_ack} = 6'h00;
    ded_pin = 1'b1;
    adr = 8'h00;
    sel = 4'hf;
    dat_i = 32'h00000000;
    pc_pins = 6'h00;
    wake = '0;
    rnd = 32'h000180de;
    tick(8);
    RESET_N <= 1'b1;
    rdc("ctrl", OFS_SENSE_CTRL, 32'h00000000);
    rdc("mask", OFS_EXT_INT_MASK, 32'h00000000);
    wb(1'b1, OFS_EXT_INT_MASK, 32'h000000ff);
    rdc("mask", OFS_EXT_INT_MASK, 32'h00000060);
    rdc("hole", 8'h14, 32'h00000000);
    wb(1'b1, OFS_EXT_INT_MASK, 32'h00000040);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, OFS_SENSE_CTRL, {30'h0, m[1:0]});
      wb(1'b1, OFS_FLAGS, 32'h00000003);
      ded_pin <= 1'b0;
      tick(8);
      rdc("fall flag", OFS_FLAGS, {31'h0, m == 1 || m == 2});
      chk("irq no gie", 32'h0, {31'h0, irq_d});
      wb(1'b1, OFS_FLAGS, 32'h00000003);
      ded_pin <= 1'b1;
      tick(8);
      rdc("rise flag", OFS_FLAGS, {31'h0, m == 1 || m == 3});
    end
    wb(1'b1, OFS_SENSE_CTRL, 32'h00000000);
    wb(1'b1, OFS_FLAGS, 32'h00000003);
    gie <= 1'b1;
    ded_pin <= 1'b0;
    tick(30);
    chk("low irq", 32'h1, {31'h0, irq_d});
    rdc("low flag", OFS_FLAGS, 32'h00000000);
    ded_pin <= 1'b1;
    tick(8);
    chk("low irq end", 32'h0, {31'h0, irq_d});
    wb(1'b1, OFS_SENSE_CTRL, 32'h00000003);
    wb(1'b1, OFS_FLAGS, 32'h00000003);
    ded_pin <= 1'b0;
    tick(4);
    ded_pin <= 1'b1;
    tick(8);
    chk("edge irq", 32'h1, {31'h0, irq_d});
    auto_ack <= 1'b1;
    tick(8);
    rdc("acked flag", OFS_FLAGS, 32'h00000000);
    auto_ack <= 1'b0;
    wb(1'b1, OFS_EXT_INT_MASK, 32'h00000020);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wb(1'b1, OFS_PC_MASK, {26'h0, rnd[5:0]});
      wb(1'b1, OFS_FLAGS, 32'h00000003);
      expv = |(rnd[5:0] & rnd[13:8]);
      pc_pins <= pc_pins ^ rnd[13:8];
      tick(8);
      chk("pc irq", {31'h0, expv}, {31'h0, irq_p});
      rdc("pc flag", OFS_FLAGS, {30'h0, expv, 1'b0});
    end
    wb(1'b1, OFS_PC_MASK, 32'h00000001);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, OFS_SENSE_CTRL, {24'h0, 3'h1, m[1:0], 3'h3});
      wb(1'b1, OFS_FLAGS, 32'h00000003);
      sleep_cmd <= 1'b1;
      tick(1);
      sleep_cmd <= 1'b0;
      tick(3);
      chk("clocks", {27'h0, clkexp[m]}, {27'h0, clk_en});
      chk("ded clamp", {31'h0, m >= 2}, {31'h0, ded_clamp});
      chk("pc clamp", (m >= 2) ? 32'h3e : 32'h0, {26'h0, pc_clamp});
      wake.converter <= 1'b1;
      tick(6);
      chk("asleep", {31'h0, m >= 2}, {31'h0, sleeping});
      if (m >= 2) begin
        rdc("status", OFS_STATUS, {23'h0, 2'h3, 5'h00, pc_pins[0], 1'b0});
      end
      wake.converter <= 1'b0;
      pc_pins[0] <= ~pc_pins[0];
      n = 0;
      while (sleeping !== 1'b0 && n < 40) begin
        tick(1);
        n++;
      end
      chk("awake", 32'h0, {31'h0, sleeping});
      tick(8);
      rdc("resume flags", OFS_FLAGS, {30'h0, 1'b1, m >= 2});
    end
    give_verdict();
  end
endmodule
